/* File: erc_regs.vh */
// constants for the execution pipeline recirculation control block
// What this block does
// [RQ1] alu lanes bypass results from execute stage (one shared bypass, lane one wins when both issue)
// [RQ2] memory lane bypasses only from cache/miss
// [RQ3] loads start cache access, address in execute
// [RQ4] fp operands read in execute, bypass end
// [RQ5] branch resolves in execute, flags mispredict
// [RQ6] indirect jump target computed, sent fetch
// [RQ7] unsigned word and doubleword load in cache
// [RQ8] translation and prefetch start cache, ready miss
// [RQ9] special unit result at cache end
// [RQ10] alu lanes write working file in cache (one result only, lane one wins when both issue)
// [RQ11] fp runs cache, miss, write; ends extend
// [RQ12] miss found by comparing physical tags
// [RQ13] signed and narrow loads align in miss
// [RQ14] fp load data delivered in miss stage
// [RQ15] memory lane writes back, requests l2 (write-back dropped when an alu write in cache takes the port)
// [RQ16] extend fp result bypasses to cache entry
// [RQ17] copy committed file on trap, recirculate
// [RQ18] trap kills trapping and younger results
// [RQ19] commit writes architectural and fp files
// [RQ20] late dependency recirculates from offending pc
// [RQ21] recirculated instruction issued alone, held
// [RQ22] missed load waits fill, two helpers follow
`ifndef ERC_REGS_VH
`define ERC_REGS_VH
// load size codes
`define ERC_LD_X   3'h0
`define ERC_LD_UW  3'h1
`define ERC_LD_SW  3'h2
`define ERC_LD_H   3'h3
`define ERC_LD_B   3'h4
// stage indexes of the shared pipe stage
`define ERC_ST_E   3'h0
`define ERC_ST_C   3'h1
`define ERC_ST_M   3'h2
`define ERC_ST_W   3'h3
`define ERC_ST_X   3'h4
`define ERC_ST_T   3'h5
`define ERC_ST_D   3'h6
`define ERC_NSTAGE 7
`define ERC_HELPERS 2'h2
`endif

/* File: erc_stage_reg.v */
// one pipeline stage register with valid and kill
`timescale 1ns/1ps
`default_nettype none
module erc_stage_reg #(
  parameter W = 8
) (
  input  wire         mclk,
  input  wire         rst_n,
  input  wire         kill,
  input  wire         in_vld,
  input  wire [W-1:0] in_dat,
  output reg          out_vld,
  output reg  [W-1:0] out_dat
);
  // kill drops the valid, the payload is left stale on purpose
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_vld <= 1'b0;
      out_dat <= {W{1'b0}};
    end else begin
      out_vld <= in_vld & ~kill;
      out_dat <= in_dat;
    end
  end
endmodule // erc_stage_reg
`default_nettype wire

/* File: erc_exec_pipe.v */
// back half of the in-order execution pipeline with trap and recirculation
`timescale 1ns/1ps
`default_nettype none
`include "erc_regs.vh"
module erc_exec_pipe #(
  parameter XW = 64,
  parameter RW = 5,
  parameter AW = 64,
  parameter PW = 40
) (
  input  wire          mclk,
  input  wire          rstn,
  // integer_alu_lane_zero / one issue (execute stage)
  input  wire          a0_vld,
  input  wire [1:0]    a0_op,
  input  wire [RW-1:0] a0_rd,
  input  wire [XW-1:0] a0_src1,
  input  wire [XW-1:0] a0_src2,
  input  wire          a1_vld,
  input  wire [1:0]    a1_op,
  input  wire [RW-1:0] a1_rd,
  input  wire [XW-1:0] a1_src1,
  input  wire [XW-1:0] a1_src2,
  // memory_special_lane issue
  input  wire          ms_vld,
  input  wire          ms_load,
  input  wire          ms_fpload,
  input  wire          ms_jump,
  input  wire          ms_special,
  input  wire [2:0]    ms_size,
  input  wire [RW-1:0] ms_rd,
  input  wire [XW-1:0] ms_base,
  input  wire [XW-1:0] ms_offs,
  input  wire [AW-1:0] ms_pc,
  // branch_lane issue
  input  wire          br_vld,
  input  wire          br_pred,
  input  wire          br_taken,
  // fp_add_lane / fp_multiply_lane issue
  input  wire          fp_vld,
  input  wire [RW-1:0] fp_rd,
  input  wire [XW-1:0] fp_src,
  // cache and translation results
  input  wire [XW-1:0] dc_data,
  input  wire [PW-1:0] dc_tag_pa,
  input  wire [PW-1:0] tlb_pa,
  input  wire          trap_req,
  input  wire          late_dep,
  input  wire          dep_clear,
  input  wire          fill_ready,
  // outputs
  output reg  [XW-1:0] byp_e,
  output reg           byp_e_vld,
  output reg  [XW-1:0] byp_cm,
  output reg           byp_cm_vld,
  output reg  [XW-1:0] fp_byp,
  output reg           fp_byp_vld,
  output reg  [AW-1:0] dc_vaddr,
  output reg           dc_start,
  output reg           tlb_start,
  output reg           pcache_start,
  output reg           mispredict,
  output reg           jump_vld,
  output reg  [AW-1:0] jump_target,
  output reg  [XW-1:0] fp_load_data,
  output reg           fp_load_vld,
  output reg           wrf_we,
  output reg  [RW-1:0] wrf_addr,
  output reg  [XW-1:0] wrf_data,
  output reg           l2_req,
  output reg  [PW-1:0] l2_addr,
  output reg           arf_we,
  output reg  [RW-1:0] arf_addr,
  output reg  [XW-1:0] arf_data,
  output reg           frf_we,
  output reg  [RW-1:0] frf_addr,
  output reg  [XW-1:0] frf_data,
  output reg           restore_wrf,
  output reg           recirc,
  output reg  [AW-1:0] recirc_pc,
  output reg           hold_single,
  output reg           helper_vld,
  output reg           dispatch_stall
);
  // reset release through two flip-flops
  reg rst_s1;
  reg rst_n;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // alu arithmetic shared by both lanes
  function [XW-1:0] alu;
    input [1:0]    op;
    input [XW-1:0] a;
    input [XW-1:0] b;
    begin
      case (op)
        2'h0:    alu = a + b;
        2'h1:    alu = a - b;
        2'h2:    alu = a << b[5:0];
        default: alu = a & b;
      endcase
    end
  endfunction

  // align and extend narrow loads
  function [XW-1:0] ld_align;
    input [2:0]    sz;
    input [XW-1:0] d;
    begin
      case (sz)
        `ERC_LD_SW: ld_align = {{(XW-32){d[31]}}, d[31:0]};
        `ERC_LD_H:  ld_align = {{(XW-16){d[15]}}, d[15:0]};
        `ERC_LD_B:  ld_align = {{(XW-8){d[7]}}, d[7:0]};
        default:    ld_align = d;
      endcase
    end
  endfunction

  wire kill = trap_req | late_dep;

  // execute stage: alu results and bypass, only alu lanes feed it
  wire [XW-1:0] a0_res = alu(a0_op, a0_src1, a0_src2);
  wire [XW-1:0] a1_res = alu(a1_op, a1_src1, a1_src2);
  wire [XW-1:0] ms_va  = ms_base + ms_offs; // sum addressed decode target
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      byp_e     <= {XW{1'b0}};
      byp_e_vld <= 1'b0;
    end else begin
      byp_e     <= a1_vld ? a1_res : a0_res;         // RQ1
      byp_e_vld <= (a0_vld | a1_vld) & ~kill;        // RQ1
    end
  end

  // execute stage: load address, branch, jump target
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dc_vaddr    <= {AW{1'b0}};
      dc_start    <= 1'b0;
      mispredict  <= 1'b0;
      jump_vld    <= 1'b0;
      jump_target <= {AW{1'b0}};
    end else begin
      dc_vaddr    <= ms_va[AW-1:0];                  // RQ3
      dc_start    <= ms_vld & ms_load & ~kill;       // RQ3
      mispredict  <= br_vld & (br_pred != br_taken); // RQ5
      jump_vld    <= ms_vld & ms_jump & ~kill;       // RQ6
      jump_target <= ms_va[AW-1:0];                  // RQ6
    end
  end

  // payload carried down the memory lane: load,fpload,special,size,rd,va
  localparam MSW = 3 + 3 + RW + XW;
  wire [MSW-1:0] ms_e_dat = {ms_load, ms_fpload, ms_special, ms_size, ms_rd, ms_va};
  wire           ms_c_vld, ms_m_vld, ms_w_vld;
  wire [MSW-1:0] ms_c_dat, ms_m_dat, ms_w_dat;
  erc_stage_reg #(.W(MSW)) u_ms_c (
    .mclk(mclk), .rst_n(rst_n), .kill(kill), .in_vld(ms_vld & ~ms_jump),
    .in_dat(ms_e_dat), .out_vld(ms_c_vld), .out_dat(ms_c_dat));
  erc_stage_reg #(.W(MSW)) u_ms_m (
    .mclk(mclk), .rst_n(rst_n), .kill(kill), .in_vld(ms_c_vld),
    .in_dat(ms_c_dat), .out_vld(ms_m_vld), .out_dat(ms_m_dat));
  erc_stage_reg #(.W(MSW)) u_ms_w (
    .mclk(mclk), .rst_n(rst_n), .kill(kill), .in_vld(ms_m_vld),
    .in_dat(ms_m_dat), .out_vld(ms_w_vld), .out_dat(ms_w_dat));

  wire          c_load  = ms_c_dat[MSW-1];
  wire          c_fpld  = ms_c_dat[MSW-2];
  wire          c_spec  = ms_c_dat[MSW-3];
  wire [2:0]    c_size  = ms_c_dat[MSW-4:MSW-6];
  wire          m_load  = ms_m_dat[MSW-1];
  wire          m_fpld  = ms_m_dat[MSW-2];
  wire [2:0]    m_size  = ms_m_dat[MSW-4:MSW-6];
  wire [RW-1:0] w_rd    = ms_w_dat[XW+RW-1:XW];
  wire          c_fast  = (c_size == `ERC_LD_X) | (c_size == `ERC_LD_UW);
  wire          m_slow  = ~((m_size == `ERC_LD_X) | (m_size == `ERC_LD_UW));

  // miss-stage results land on the edge that raises ms_w_vld, so they line up
  reg [XW-1:0] c_res;
  reg [XW-1:0] w_res;
  reg          w_miss;
  reg [PW-1:0] w_pa;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      c_res  <= {XW{1'b0}};
      w_res  <= {XW{1'b0}};
      w_miss <= 1'b0;
      w_pa   <= {PW{1'b0}};
    end else begin
      c_res  <= c_load ? dc_data : ms_c_dat[XW-1:0];
      w_res  <= m_load ? ld_align(m_size, c_res) : c_res;       // RQ13
      w_miss <= ms_m_vld & m_load & (tlb_pa != dc_tag_pa);       // RQ12
      w_pa   <= tlb_pa;
    end
  end

  // cache-stage starts and the memory-lane bypass, never from execute
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tlb_start    <= 1'b0;
      pcache_start <= 1'b0;
      byp_cm       <= {XW{1'b0}};
      byp_cm_vld   <= 1'b0;
    end else begin
      tlb_start    <= ms_c_vld & c_load;                          // RQ8
      pcache_start <= ms_c_vld & c_fpld;                          // RQ8
      if (ms_c_vld & c_load & c_fast & ~c_fpld) begin
        byp_cm     <= dc_data;                                    // RQ7
        byp_cm_vld <= ~kill;                                      // RQ2
      end else if (ms_c_vld & c_spec) begin
        byp_cm     <= ms_c_dat[XW-1:0];                           // RQ9
        byp_cm_vld <= ~kill;                                      // RQ9
      end else if (ms_m_vld & m_load & m_slow & ~m_fpld) begin
        byp_cm     <= ld_align(m_size, c_res);                    // RQ13
        byp_cm_vld <= ~kill;                                      // RQ2
      end else begin
        byp_cm_vld <= 1'b0;
      end
    end
  end

  // fp load data to fp lanes in miss stage
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fp_load_data <= {XW{1'b0}};
      fp_load_vld  <= 1'b0;
    end else begin
      fp_load_data <= c_res;                                      // RQ14
      fp_load_vld  <= ms_m_vld & m_fpld & ~kill;                  // RQ14
    end
  end

  // one alu lane carried into cache stage for working file write, lane one when both issue
  wire          al_c_vld;
  wire [RW+XW-1:0] al_c_dat;
  erc_stage_reg #(.W(RW+XW)) u_al_c (
    .mclk(mclk), .rst_n(rst_n), .kill(kill), .in_vld(a0_vld | a1_vld),
    .in_dat(a1_vld ? {a1_rd, a1_res} : {a0_rd, a0_res}),
    .out_vld(al_c_vld), .out_dat(al_c_dat));

  // working file port: alu in cache stage wins, memory lane in write stage
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrf_we   <= 1'b0;
      wrf_addr <= {RW{1'b0}};
      wrf_data <= {XW{1'b0}};
      l2_req   <= 1'b0;
      l2_addr  <= {PW{1'b0}};
    end else begin
      if (al_c_vld) begin
        wrf_we   <= 1'b1;                                         // RQ10
        wrf_addr <= al_c_dat[RW+XW-1:XW];
        wrf_data <= al_c_dat[XW-1:0];
      end else begin
        wrf_we   <= ms_w_vld & ~w_miss;                           // RQ15
        wrf_addr <= w_rd;
        wrf_data <= w_res;
      end
      l2_req  <= ms_w_vld & w_miss;                               // RQ15
      l2_addr <= w_pa;
    end
  end

  // fp pipe: operands in execute, cycles in c, m, w, done in x
  wire [XW-1:0] fp_opnd = (fp_byp_vld) ? fp_byp : fp_src;         // RQ4
  wire          fp_c_vld, fp_m_vld, fp_w_vld, fp_x_vld;
  wire [RW+XW-1:0] fp_c_dat, fp_m_dat, fp_w_dat, fp_x_dat;
  erc_stage_reg #(.W(RW+XW)) u_fp_c (
    .mclk(mclk), .rst_n(rst_n), .kill(kill), .in_vld(fp_vld),
    .in_dat({fp_rd, fp_opnd}), .out_vld(fp_c_vld), .out_dat(fp_c_dat));
  erc_stage_reg #(.W(RW+XW)) u_fp_m (
    .mclk(mclk), .rst_n(rst_n), .kill(kill), .in_vld(fp_c_vld),
    .in_dat(fp_c_dat), .out_vld(fp_m_vld), .out_dat(fp_m_dat));   // RQ11
  erc_stage_reg #(.W(RW+XW)) u_fp_w (
    .mclk(mclk), .rst_n(rst_n), .kill(kill), .in_vld(fp_m_vld),
    .in_dat(fp_m_dat), .out_vld(fp_w_vld), .out_dat(fp_w_dat));   // RQ11
  erc_stage_reg #(.W(RW+XW)) u_fp_x (
    .mclk(mclk), .rst_n(rst_n), .kill(kill), .in_vld(fp_w_vld),
    .in_dat(fp_w_dat), .out_vld(fp_x_vld), .out_dat(fp_x_dat));   // RQ11

  // extend-stage result offered to the op entering cache next cycle
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fp_byp     <= {XW{1'b0}};
      fp_byp_vld <= 1'b0;
    end else begin
      fp_byp     <= fp_x_dat[XW-1:0];                             // RQ16
      fp_byp_vld <= fp_x_vld & ~kill;                             // RQ16
    end
  end

  // memory lane passes extend too, so its trap stage lines up with the fp lanes
  // a trap drops what moves into trap and into done, younger ones never commit
  wire          xi_vld, ti_vld, tf_vld, di_vld, df_vld;
  wire [RW+XW-1:0] xi_dat, ti_dat, tf_dat, di_dat, df_dat;
  erc_stage_reg #(.W(RW+XW)) u_xi (
    .mclk(mclk), .rst_n(rst_n), .kill(kill), .in_vld(ms_w_vld & ~w_miss),
    .in_dat({w_rd, w_res}), .out_vld(xi_vld), .out_dat(xi_dat));
  erc_stage_reg #(.W(RW+XW)) u_ti (
    .mclk(mclk), .rst_n(rst_n), .kill(trap_req), .in_vld(xi_vld),
    .in_dat(xi_dat), .out_vld(ti_vld), .out_dat(ti_dat));          // RQ18
  erc_stage_reg #(.W(RW+XW)) u_tf (
    .mclk(mclk), .rst_n(rst_n), .kill(trap_req), .in_vld(fp_x_vld),
    .in_dat(fp_x_dat), .out_vld(tf_vld), .out_dat(tf_dat));
  erc_stage_reg #(.W(RW+XW)) u_di (
    .mclk(mclk), .rst_n(rst_n), .kill(trap_req), .in_vld(ti_vld),
    .in_dat(ti_dat), .out_vld(di_vld), .out_dat(di_dat));          // RQ18
  erc_stage_reg #(.W(RW+XW)) u_df (
    .mclk(mclk), .rst_n(rst_n), .kill(trap_req), .in_vld(tf_vld),
    .in_dat(tf_dat), .out_vld(df_vld), .out_dat(df_dat));          // RQ18

  // commit writes into the architectural and fp files
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arf_we   <= 1'b0;
      arf_addr <= {RW{1'b0}};
      arf_data <= {XW{1'b0}};
      frf_we   <= 1'b0;
      frf_addr <= {RW{1'b0}};
      frf_data <= {XW{1'b0}};
    end else begin
      arf_we   <= di_vld;                                         // RQ19
      arf_addr <= di_dat[RW+XW-1:XW];
      arf_data <= di_dat[XW-1:0];
      frf_we   <= df_vld;                                         // RQ19
      frf_addr <= df_dat[RW+XW-1:XW];
      frf_data <= df_dat[XW-1:0];
    end
  end

  // recirculation control, one-hot
  localparam S_RUN  = 4'h1;
  localparam S_HOLD = 4'h2;
  localparam S_FILL = 4'h4;
  localparam S_HELP = 4'h8;
  reg [3:0]    state;
  reg [3:0]    next_state;
  reg [1:0]    help_cnt;
  reg [AW-1:0] w_pc;
  reg [AW-1:0] m_pc;
  reg [AW-1:0] c_pc;
  // pc follows the memory lane so recirculation restarts at the offender
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      c_pc <= {AW{1'b0}};
      m_pc <= {AW{1'b0}};
      w_pc <= {AW{1'b0}};
    end else begin
      c_pc <= ms_pc;
      m_pc <= c_pc;
      w_pc <= m_pc;
    end
  end

  wire miss_event = ms_w_vld & w_miss;
  always @* begin
    next_state = state;
    case (state)
      S_RUN:   if (miss_event) next_state = S_FILL;              // RQ22
               else if (late_dep) next_state = S_HOLD;           // RQ20
      S_HOLD:  if (dep_clear) next_state = S_RUN;                // RQ21
      S_FILL:  if (fill_ready) next_state = S_HELP;              // RQ22
      S_HELP:  if (help_cnt == 2'h1) next_state = S_RUN;
      default: next_state = S_RUN;
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state          <= S_RUN;
      help_cnt       <= 2'h0;
      recirc         <= 1'b0;
      recirc_pc      <= {AW{1'b0}};
      restore_wrf    <= 1'b0;
      hold_single    <= 1'b0;
      helper_vld     <= 1'b0;
      dispatch_stall <= 1'b0;
    end else begin
      state       <= next_state;
      recirc      <= (state == S_RUN) & (miss_event | late_dep);  // RQ20
      recirc_pc   <= w_pc;                                        // RQ20
      restore_wrf <= trap_req | ((state == S_RUN) & (miss_event | late_dep)); // RQ17
      // offender goes alone and waits for its dependency or fill data
      hold_single <= (next_state == S_HOLD) | (next_state == S_FILL); // RQ21
      dispatch_stall <= next_state != S_RUN;                      // RQ20
      if (state == S_FILL && fill_ready) begin
        help_cnt <= `ERC_HELPERS;                                 // RQ22
      end else if (help_cnt != 2'h0) begin
        help_cnt <= help_cnt - 2'h1;
      end
      helper_vld <= next_state == S_HELP;                         // RQ22
    end
  end
endmodule // erc_exec_pipe
`default_nettype wire

/* File: erc_exec_pipe_chk.sv */
// concurrent checks on the execution pipeline ports
`timescale 1ns/1ps
`default_nettype none
module erc_exec_pipe_chk #(
  parameter XW = 64,
  parameter RW = 5,
  parameter AW = 64
) (
  input wire logic          mclk,
  input wire logic          rstn,
  input wire logic          a0_vld,
  input wire logic          a1_vld,
  input wire logic [RW-1:0] a1_rd,
  input wire logic          ms_vld,
  input wire logic          ms_load,
  input wire logic          ms_jump,
  input wire logic [XW-1:0] ms_base,
  input wire logic [XW-1:0] ms_offs,
  input wire logic          br_vld,
  input wire logic          br_pred,
  input wire logic          br_taken,
  input wire logic          fp_vld,
  input wire logic          trap_req,
  input wire logic          late_dep,
  input wire logic          byp_e_vld,
  input wire logic          mispredict,
  input wire logic          jump_vld,
  input wire logic [AW-1:0] jump_target,
  input wire logic          dc_start,
  input wire logic [AW-1:0] dc_vaddr,
  input wire logic          tlb_start,
  input wire logic          fp_byp_vld,
  input wire logic          arf_we,
  input wire logic          frf_we,
  input wire logic          wrf_we,
  input wire logic [RW-1:0] wrf_addr,
  input wire logic          helper_vld,
  input wire logic          recirc,
  input wire logic          hold_single,
  input wire logic          dispatch_stall,
  input wire logic          l2_req
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // a kill in a cycle may cancel anything launched then, so those cycles are left out
  wire quiet = !trap_req && !late_dep;

  a_alu_bypass: assert property ((a0_vld || a1_vld) && quiet |=> byp_e_vld)
    else $error("alu result not bypassed from execute");
  a_ebyp_source: assert property (!a0_vld && !a1_vld |=> !byp_e_vld)
    else $error("execute bypass without an alu issue");
  a_branch_dir: assert property (br_vld && quiet |=> mispredict == $past(br_pred) ^ $past(br_taken))
    else $error("mispredict does not match resolved direction");
  a_jump_target: assert property (ms_vld && ms_jump && quiet |=>
    jump_vld && jump_target == $past(ms_base) + $past(ms_offs))
    else $error("jump target wrong or late");
  a_load_start: assert property (ms_vld && ms_load && quiet |=>
    dc_start && dc_vaddr == $past(ms_base) + $past(ms_offs))
    else $error("load cache access not started in execute");
  a_tlb_cstage: assert property (ms_vld && ms_load && quiet ##1 quiet |=> tlb_start)
    else $error("translation not started in cache stage");
  a_fp_extend: assert property (fp_vld && quiet ##1 quiet [*4] |=> fp_byp_vld)
    else $error("fp result not bypassed after extend");
  a_alu_write: assert property (a1_vld && quiet ##1 quiet |=>
    wrf_we && wrf_addr == $past(a1_rd, 2))
    else $error("alu write to working file missing");
  a_trap_commit: assert property (trap_req |=> ##1 !arf_we && !frf_we)
    else $error("commit after trap");
  a_helper_pair: assert property ($rose(helper_vld) |=> helper_vld ##1 !helper_vld)
    else $error("helper count not two");
  a_recirc_hold: assert property (recirc |-> ##[0:1] hold_single)
    else $error("recirculated instruction not held alone");
  a_miss_l2: assert property (l2_req |-> recirc && dispatch_stall)
    else $error("l2 request without recirculation");
endmodule // erc_exec_pipe_chk
`default_nettype wire

/* File: erc_far_model.sv */
// l2 fill model facing the pipeline
`timescale 1ns/1ps
`default_nettype none
module erc_far_model (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       l2_req,
  input  wire logic       helper_vld,
  input  wire logic [7:0] fill_lat,
  output var  logic       fill_ready
);
  logic [7:0] cnt;
  // fill lands fill_lat cycles after the request, dropped once helpers drain it
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 8'h0;
      fill_ready <= 1'b0;
    end else if (l2_req) begin
      cnt <= fill_lat;
    end else if (cnt > 8'h1) begin
      cnt <= cnt - 8'h1;
    end else if (cnt == 8'h1) begin
      cnt <= 8'h0;
      fill_ready <= 1'b1;
    end else if (helper_vld) begin
      fill_ready <= 1'b0;
    end
  end
endmodule // erc_far_model
`default_nettype wire

/* File: erc_exec_pipe_tb_top.sv */
// self-checking bench for the execution pipeline block
`timescale 1ns/1ps
`default_nettype none
module erc_exec_pipe_tb_top;
  typedef struct packed {logic l; logic [1:0] op; logic [63:0] s1, s2, e;} erc_row_t;
  logic        mclk = 0, rstn = 0, a0_vld = 0, a1_vld = 0, ms_vld = 0, ms_load = 0;
  logic        ms_fpload = 0, ms_jump = 0, ms_special = 0, br_vld = 0, br_pred = 0;
  logic        br_taken = 0, fp_vld = 0, trap_req = 0, late_dep = 0, dep_clear = 0;
  logic [1:0]  a0_op = 0, a1_op = 0;
  logic [2:0]  ms_size = 0;
  logic [4:0]  a0_rd = 0, a1_rd = 0, ms_rd = 5'h7, fp_rd = 5'h3, wrf_addr, arf_addr, frf_addr;
  logic [7:0]  fill_lat = 8'h1;
  logic [63:0] a0_src1 = 0, a0_src2 = 0, a1_src1 = 0, a1_src2 = 0, ms_base = 64'h1000;
  logic [63:0] ms_offs = 64'h8, ms_pc = 64'h400, fp_src = 64'h5, dc_data = 64'h88776655c433a2f1;
  // sign-extended results of the signed word, half and byte loads of dc_data
  logic [63:0] nexp [5] = '{64'h0, 64'h0, 64'hffffffffc433a2f1, 64'hffffffffffffa2f1,
                            64'hfffffffffffffff1};
  logic [63:0] byp_e, byp_cm, fp_byp, dc_vaddr, jump_target, fp_load_data, wrf_data, arf_data;
  logic [63:0] frf_data, recirc_pc;
  logic [39:0] dc_tag_pa = 40'h12340, tlb_pa = 40'h12340, l2_addr;
  logic        byp_e_vld, byp_cm_vld, fp_byp_vld, dc_start, tlb_start, pcache_start, mispredict;
  logic        jump_vld, fp_load_vld, wrf_we, l2_req, arf_we, frf_we, restore_wrf, recirc;
  logic        hold_single, helper_vld, dispatch_stall, fill_ready, seen, bad;
  int          n_errors = 0, total_checks = 0, cycles = 0, k;
  erc_row_t    rows [6] = '{
    '{1'b0, 2'h0, 64'h10, 64'h7, 64'h17}, '{1'b1, 2'h1, 64'h10, 64'h7, 64'h9},
    '{1'b0, 2'h2, 64'h3, 64'h4, 64'h30}, '{1'b1, 2'h3, 64'hf0f0, 64'hff00, 64'hf000},
    '{1'b0, 2'h1, 64'h0, 64'h1, 64'hffffffffffffffff}, '{1'b1, 2'h2, 64'h9, 64'h0, 64'h9}};

  erc_exec_pipe dut (.*);
  erc_far_model far (.mclk, .rstn, .l2_req, .helper_vld, .fill_lat, .fill_ready);

  always #5 mclk = ~mclk;
  // a hang would otherwise stop the closing report from ever printing
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize;
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // one memory lane issue; returns in the cycle after execute
  task automatic ms_issue(input logic ld, fl, jp, sp, input logic [2:0] sz);
    {ms_vld, ms_load, ms_fpload, ms_jump, ms_special, ms_size} = {1'b1, ld, fl, jp, sp, sz};
    step(1);
    ms_vld = 0;
  endtask

  initial begin
    step(16);
    rstn = 1;
    step(3);
    chk({byp_e_vld, dc_start, mispredict, wrf_we, arf_we, recirc, hold_single, l2_req} === 0,
        "outputs busy after reset");
    // alu rows, one issued every other cycle
    foreach (rows[i]) begin
      {a0_vld, a1_vld, a0_op, a1_op, a0_rd, a1_rd} = {~rows[i].l, rows[i].l, {2{rows[i].op}},
                                                      {2{i[4:0]}}};
      {a0_src1, a0_src2, a1_src1, a1_src2} = {2{rows[i].s1, rows[i].s2}};
      step(1);
      {a0_vld, a1_vld} = 2'b00;
      chk(byp_e_vld === 1 && byp_e === rows[i].e, "alu bypass");
      step(1);
      chk(wrf_we === 1 && wrf_addr === i[4:0] && wrf_data === rows[i].e, "alu write");
    end
    // every load size, then walk the load down to commit
    for (logic [2:0] s = 0; s < 5; s++) begin
      ms_issue(1, 0, 0, 0, s);
      chk(dc_start === 1 && dc_vaddr === 64'h1008, "load start");
      step(1);
      chk(byp_cm_vld === (s < 2) && tlb_start === 1 && (s != 0 || byp_cm === dc_data), "c");
      step(1);
      chk(byp_cm_vld === (s >= 2) && (s < 2 || byp_cm === nexp[s]), "narrow load");
      step(1);
      chk(wrf_we === 1 && l2_req === 0, "memory lane write");
      step(3);
      chk(arf_we === 1 && arf_addr === ms_rd && (s < 2 || arf_data === nexp[s]), "load");
    end
    ms_issue(0, 0, 0, 1, 0);
    chk(byp_e_vld === 0, "special bypass in execute");
    step(1);
    chk(byp_cm_vld === 1, "special bypass");
    ms_issue(0, 0, 1, 0, 0);
    chk(jump_vld === 1 && jump_target === 64'h1008, "jump target");
    ms_issue(1, 1, 0, 0, 0);
    step(1);
    chk(pcache_start === 1, "prefetch start");
    step(1);
    chk(fp_load_vld === 1 && fp_load_data === dc_data, "fp load data");
    for (int b = 0; b < 4; b++) begin
      {br_vld, br_pred, br_taken} = {1'b1, b[1:0]};
      step(1);
      br_vld = 0;
      chk(mispredict === (br_pred ^ br_taken), "mispredict");
    end
    // fp op to commit, then the same op trapped in its trap stage
    for (int t = 0; t < 2; t++) begin
      fp_vld = 1;
      step(1);
      fp_vld = 0;
      step(4);
      chk(fp_byp_vld === 1 && fp_byp === fp_src, "fp extend bypass");
      trap_req = t[0];
      step(1);
      trap_req = 0;
      {seen, bad} = 2'b00;
      repeat (3) begin
        seen |= restore_wrf;
        bad |= (frf_we && frf_addr === fp_rd && frf_data === fp_src);
        step(1);
      end
      chk(bad === !t[0] && seen === t[0], "fp commit or trap");
    end
    // load misses with a quick and a slow fill
    for (int j = 0; j < 2; j++) begin
      fill_lat = j ? 8'd20 : 8'd1;
      tlb_pa = 40'h55000;
      ms_issue(1, 0, 0, 0, 0);
      ms_pc = ~ms_pc; // the recirculation pc must stay the offender's
      step(3);
      chk(l2_req === 1 && l2_addr === tlb_pa && recirc === 1 && recirc_pc === ~ms_pc,
          "miss");
      chk(restore_wrf === 1 && hold_single === 1 && dispatch_stall === 1, "miss hold");
      tlb_pa = dc_tag_pa;
      for (k = 0; k < 40 && helper_vld !== 1; k++) step(1);
      chk(fill_ready === 1 && helper_vld === 1 && dispatch_stall === 1, "helper start");
      step(1);
      chk(helper_vld === 1, "second helper");
      step(1);
      chk(helper_vld === 0, "third helper");
      for (k = 0; k < 3 && dispatch_stall !== 0; k++) step(1);
      chk(dispatch_stall === 0 && hold_single === 0, "regroup after helpers");
    end
    // late dependency, held until cleared
    late_dep = 1;
    step(1);
    late_dep = 0;
    seen = 0;
    repeat (3) begin
      seen |= recirc;
      step(1);
    end
    chk(seen === 1 && hold_single === 1, "late dependency");
    dep_clear = 1;
    step(1);
    dep_clear = 0;
    step(2);
    chk(hold_single === 0, "hold released");
    summarize();
  end
endmodule // erc_exec_pipe_tb_top

bind erc_exec_pipe erc_exec_pipe_chk #(.XW(XW), .RW(RW), .AW(AW)) u_chk (.*);
`default_nettype wire
